/* rtl/tpc_timer.sv */
// Sixteen-bit timer with PWM, capture, compare and gated modes.
`timescale 1ns/10ps
`include "tpc_defines.svh"
module tpc_timer
  import tpc_pkg::*;
(
  input  wire logic                   sys_clk,                // System clock, 250 MHz.
  input  wire logic                   sys_rst,                // Asynchronous reset, active high.
  input  wire logic                   timer_enable,           // Timer runs while high.
  input  wire tpc_mode_t              mode_select,            // Operating mode.
  input  wire logic [`TPC_PRE_W-1:0]  prescale_minus_one,     // Divide ratio minus one.
  input  wire logic                   output_polarity_select, // Output start level / input edge.
  input  wire logic                   output_function_enable, // Output alternate function on.
  input  wire logic [`TPC_CNT_W-1:0]  reload_value,           // Reload or compare value.
  input  wire logic                   count_write,            // Load start count, one pulse.
  input  wire logic [`TPC_CNT_W-1:0]  count_write_value,      // Start count value.
  input  wire logic                   pwm_write,              // Load PWM value, one pulse.
  input  wire logic [`TPC_CNT_W-1:0]  pwm_write_value,        // PWM match value.
  input  wire logic                   timer_in_pin,           // Timer input pin, asynchronous.
  output logic                        timer_out,              // Timer output pin level.
  output logic                        timer_irq,              // Interrupt, one-cycle pulse.
  output logic [`TPC_CNT_W-1:0]       count_value,            // Running count.
  output logic [`TPC_CNT_W-1:0]       pwm_value,              // PWM match or captured value.
  output logic                        timer_in_level          // Synchronised input level.
);

  // ==========================================================================
  // Input synchroniser.
  // ==========================================================================
  logic [`TPC_SYNC_W-1:0] sync_q;
  logic [`TPC_SYNC_W-1:0] sync_d;
  logic                   in_lvl_q;
  logic                   in_lvl_d;

  always_comb
  begin
    sync_d   = {sync_q[`TPC_SYNC_W-2:0], timer_in_pin};
    // A change counts only once the second and third stages agree.
    in_lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : in_lvl_q;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_q   <= '0;
      in_lvl_q <= 1'b0;
    end
    else
    begin
      sync_q   <= sync_d;
      in_lvl_q <= in_lvl_d;
    end
  end

  // Edges come from a change of the filtered level itself, so a polarity
  // write or the release of reset can never fake a capture or a deassertion.
  logic in_active;
  logic in_lvl_prev_q;
  logic in_change;
  logic cap_edge;
  logic gate_fall;

  assign in_active = (in_lvl_q == output_polarity_select);
  assign in_change = (in_lvl_q != in_lvl_prev_q);
  assign cap_edge  = in_active & in_change;
  assign gate_fall = ~in_active & in_change;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      in_lvl_prev_q <= 1'b0;
    end
    else
    begin
      in_lvl_prev_q <= in_lvl_q;
    end
  end

  // ==========================================================================
  // Prescaler.
  // ==========================================================================
  // The divider restarts while disabled so the first tick lands a full
  // prescale period after enable, which keeps period arithmetic exact.
  logic [`TPC_PRE_W-1:0] pre_q;
  logic [`TPC_PRE_W-1:0] pre_d;
  logic                  tick;

  assign tick = timer_enable && (pre_q == prescale_minus_one);

  always_comb
  begin
    if (!timer_enable || tick)
    begin
      pre_d = '0;
    end
    else
    begin
      pre_d = pre_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_d;
    end
  end

  // ==========================================================================
  // Counter, match logic and output.
  // ==========================================================================
  logic [`TPC_CNT_W-1:0] cnt_q;
  logic [`TPC_CNT_W-1:0] cnt_d;
  logic [`TPC_CNT_W-1:0] pwm_q;
  logic [`TPC_CNT_W-1:0] pwm_d;
  logic                  out_q;
  logic                  out_d;
  logic                  irq_q;
  logic                  irq_d;
  logic                  en_prev_q;
  logic                  step;
  logic                  at_reload;

  // In gated mode ticks only count while the input is active.
  assign step      = tick && ((mode_select != TPC_GATED) || in_active);
  assign at_reload = (cnt_q == reload_value);

  always_comb
  begin
    cnt_d = cnt_q;
    pwm_d = pwm_q;
    out_d = out_q;
    irq_d = 1'b0;
    // While disabled the output rests at the level the polarity bit selects.
    if (!timer_enable)
    begin
      out_d = output_polarity_select;
    end
    else if (!en_prev_q)
    begin
      out_d = output_polarity_select;
    end
    if (step)
    begin
      unique case (mode_select)
        TPC_PWM:
        begin
          if (at_reload)
          begin
            cnt_d = `TPC_CNT_RELOAD;
            irq_d = 1'b1;
            out_d = output_polarity_select;
          end
          else
          begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == pwm_q)
            begin
              out_d = ~output_polarity_select;
            end
          end
        end
        TPC_CAPTURE:
        begin
          cnt_d = cnt_q + 1'b1;
          if (at_reload)
          begin
            irq_d = 1'b1;
          end
        end
        TPC_COMPARE:
        begin
          cnt_d = cnt_q + 1'b1;
          if (at_reload)
          begin
            irq_d = 1'b1;
            if (output_function_enable)
            begin
              out_d = ~out_q;
            end
          end
        end
        TPC_GATED:
        begin
          if (at_reload)
          begin
            cnt_d = `TPC_CNT_RELOAD;
            irq_d = 1'b1;
            if (output_function_enable)
            begin
              out_d = ~out_q;
            end
          end
          else
          begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      endcase
    end
    // Capture works on system-clock edges, independent of the prescale tick.
    if (timer_enable && (mode_select == TPC_CAPTURE) && cap_edge)
    begin
      pwm_d = cnt_q;
      irq_d = 1'b1;
    end
    if (timer_enable && (mode_select == TPC_GATED) && gate_fall)
    begin
      irq_d = 1'b1;
    end
    // Software writes take priority; they are meant for a disabled timer.
    if (count_write)
    begin
      cnt_d = count_write_value;
    end
    if (pwm_write)
    begin
      pwm_d = pwm_write_value;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q     <= `TPC_CNT_RESET;
      pwm_q     <= `TPC_CNT_RESET;
      out_q     <= 1'b0;
      irq_q     <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      cnt_q     <= cnt_d;
      pwm_q     <= pwm_d;
      out_q     <= out_d;
      irq_q     <= irq_d;
      en_prev_q <= timer_enable;
    end
  end

  assign timer_out      = out_q;
  assign timer_irq      = irq_q;
  assign count_value    = cnt_q;
  assign pwm_value      = pwm_q;
  assign timer_in_level = in_lvl_q;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  a_pwm_reload_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (timer_enable && step && mode_select == TPC_PWM && at_reload && !count_write)
      |=> (cnt_q == `TPC_CNT_RELOAD) && timer_irq)
    else $error("PWM reload did not restart count with interrupt");

  a_pwm_out_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_PWM && !at_reload && cnt_q == pwm_q)
      |=> (timer_out == ~$past(output_polarity_select)))
    else $error("PWM match did not drive the active level");

  a_pwm_reload_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_PWM && at_reload)
      |=> (timer_out == $past(output_polarity_select)))
    else $error("PWM reload did not restore the start level");

  a_capture_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (timer_enable && mode_select == TPC_CAPTURE && cap_edge && !pwm_write)
      |=> (pwm_q == $past(cnt_q)) && timer_irq)
    else $error("Capture edge did not store the count");

  a_compare_nowrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_COMPARE && !count_write)
      |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("Compare mode count did not advance by one");

  a_compare_toggle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_COMPARE && at_reload && output_function_enable && en_prev_q)
      |=> (timer_out != $past(timer_out)))
    else $error("Compare match did not invert the output");

  a_gated_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_select == TPC_GATED && !in_active && !count_write)
      |=> (cnt_q == $past(cnt_q)))
    else $error("Gated count moved while input inactive");

  a_gated_fall_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (timer_enable && mode_select == TPC_GATED && gate_fall) |=> timer_irq)
    else $error("Gated deassertion raised no interrupt");

  a_prescale_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tick && prescale_minus_one != 7'h00 && $stable(prescale_minus_one)) |=> !tick)
    else $error("Prescale ticks came back to back");

  a_sync_agree: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sync_q[1] == sync_q[2]) |=> (in_lvl_q == $past(sync_q[2])))
    else $error("Synchronised input ignored agreeing stages");

  a_pwm_count_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_PWM && !at_reload && !count_write)
      |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("PWM count did not advance by one");

  a_capture_reload_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_CAPTURE && at_reload) |=> timer_irq)
    else $error("Capture mode reload raised no interrupt");

  a_capture_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!(timer_enable && mode_select == TPC_CAPTURE && cap_edge) && !pwm_write)
      |=> (pwm_q == $past(pwm_q)))
    else $error("Stored value changed without capture or write");

  a_compare_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_COMPARE && at_reload) |=> timer_irq)
    else $error("Compare match raised no interrupt");

  a_compare_output_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_COMPARE && at_reload && !output_function_enable && en_prev_q)
      |=> $stable(timer_out))
    else $error("Compare match moved a disabled output");

  a_gated_reload_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_GATED && at_reload && !count_write)
      |=> (cnt_q == `TPC_CNT_RELOAD) && timer_irq)
    else $error("Gated reload did not restart count with interrupt");

  a_gated_reload_flip: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && mode_select == TPC_GATED && at_reload && output_function_enable && en_prev_q)
      |=> (timer_out != $past(timer_out)))
    else $error("Gated reload did not invert the output");

  a_count_tick_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!step && !count_write) |=> (cnt_q == $past(cnt_q)))
    else $error("Count moved without a prescaled tick");

  a_prescale_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !timer_enable |=> (pre_q == '0))
    else $error("Prescaler did not restart while disabled");

endmodule // tpc_timer

/* rtl/tpc_defines.svh */
// Constants for the gated PWM, capture and compare timer.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_CNT_W      16
`define TPC_CNT_RESET  16'h0000
`define TPC_CNT_RELOAD 16'h0001
`define TPC_CNT_ZERO   16'h0000
`define TPC_CNT_MAX    16'hffff
`define TPC_PRE_W      7
`define TPC_SYNC_W     3
`define TPC_MODE_W     2
`endif

/* rtl/tpc_pkg.sv */
// Types for the gated PWM, capture and compare timer.
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_PWM     = 2'b00,
    TPC_CAPTURE = 2'b01,
    TPC_COMPARE = 2'b10,
    TPC_GATED   = 2'b11
  } tpc_mode_t;
endpackage

/* test/tpc_pin_model.sv */
// Behavioural driver of the timer input pin.
`timescale 1ns/10ps
module tpc_pin_model (
  input  wire logic sys_clk,    // System clock.
  input  wire logic want_level, // Level asked for by the bench.
  output logic      pin         // Timer input pin.
);
  logic       want_q;
  logic [2:0] since_q;
  initial
  begin
    pin = 1'b0;
    want_q = 1'b0;
    since_q = 3'h0;
  end
  always @(posedge sys_clk) want_q <= want_level;
  // A new level waits until the old one has stood four cycles, which keeps
  // the pin at or below an eighth of the clock rate.
  always @(negedge sys_clk)
    if (want_q != pin && since_q >= 3'h3)
    begin
      pin <= want_q;
      since_q <= 3'h0;
    end
    else if (since_q != 3'h7)
      since_q <= since_q + 3'h1;
endmodule // tpc_pin_model

/* test/tpc_timer_tb.sv */
// Self-checking bench for the sixteen-bit timer.
`timescale 1ns/10ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: %s", $time, m); end end
module tpc_timer_tb;
  import tpc_pkg::*;
  typedef struct packed {
    logic pol; logic [6:0] pre; logic [15:0] st, pw, rl; int per, hi;
  } tpc_row_t;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, timer_enable = 1'b0, pol = 1'b0, ofe = 1'b1;
  logic        count_write = 1'b0, pwm_write = 1'b0, want_level = 1'b0;
  logic        timer_in_pin, timer_out, timer_irq, timer_in_level;
  tpc_mode_t   mode_select = TPC_PWM;
  logic [6:0]  prescale_minus_one = 7'h00;
  logic [15:0] reload_value = 16'h0000, count_write_value = 16'h0000;
  logic [15:0] pwm_write_value = 16'h0000, count_value, pwm_value, c0;
  int          err_total = 0, check_count = 0, n, hi, z, f;
  // Polarity, divide-1, start, match, reload, period, cycles away from start level.
  tpc_row_t rows [4] = '{
    '{1'b0, 7'h00, 16'h0001, 16'h0002, 16'h0004, 4, 2},
    '{1'b1, 7'h00, 16'h0003, 16'h0005, 16'h0009, 9, 4},
    '{1'b0, 7'h03, 16'h0001, 16'h0001, 16'h0006, 24, 20},
    '{1'b1, 7'h7f, 16'h0002, 16'h0001, 16'h0003, 384, 256}};
  tpc_timer tpc_timer_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .timer_enable(timer_enable),
    .mode_select(mode_select), .prescale_minus_one(prescale_minus_one),
    .output_polarity_select(pol), .output_function_enable(ofe), .reload_value(reload_value),
    .count_write(count_write), .count_write_value(count_write_value), .pwm_write(pwm_write),
    .pwm_write_value(pwm_write_value), .timer_in_pin(timer_in_pin), .timer_out(timer_out),
    .timer_irq(timer_irq), .count_value(count_value), .pwm_value(pwm_value),
    .timer_in_level(timer_in_level));
  tpc_pin_model tpc_pin_model_i (.sys_clk(sys_clk), .want_level(want_level), .pin(timer_in_pin));
  always #2 sys_clk = ~sys_clk;
  // ==========================================================================
  // Tasks
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    hi = 0;
    z = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (timer_out !== pol) hi++;
      if (count_value === 16'h0000) z = 1;
    end while (timer_irq !== 1'b1 && n < lim);
    `CHK(timer_irq, 1'b1, "no interrupt")
  endtask
  // Writes land while the timer is stopped; enabling comes last.
  task automatic setup(input tpc_mode_t m, input logic p, input logic [6:0] pr,
                       input logic [15:0] st, input logic [15:0] pw, input logic [15:0] rl);
    @(negedge sys_clk);
    timer_enable = 1'b0;
    mode_select = m;
    pol = p;
    prescale_minus_one = pr;
    reload_value = rl;
    count_write = 1'b1;
    count_write_value = st;
    pwm_write = 1'b1;
    pwm_write_value = pw;
    @(negedge sys_clk);
    count_write = 1'b0;
    pwm_write = 1'b0;
    `CHK(timer_out, p, "start level")
    timer_enable = 1'b1;
  endtask
  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(({timer_out, timer_irq, timer_in_level, count_value, pwm_value}), 35'h0, "reset value")
    sys_rst = 1'b0;
    $display("test reset done");
    foreach (rows[i])
    begin
      setup(TPC_PWM, rows[i].pol, rows[i].pre, rows[i].st, rows[i].pw, rows[i].rl);
      f = (rows[i].rl - rows[i].st) * (rows[i].pre + 1);
      wait_irq(1000);
      `CHK(n inside {[f:f + rows[i].pre + 3]}, 1'b1, "first period")
      `CHK(count_value, 16'h0001, "count after reload")
      `CHK(timer_out, rows[i].pol, "level after reload")
      wait_irq(1000);
      `CHK(n, rows[i].per, "period")
      `CHK(hi, rows[i].hi, "match time")
      $display("test pwm row %0d done", i);
    end
    setup(TPC_COMPARE, 1'b0, 7'h01, 16'hfffd, 16'h0000, 16'h0002);
    wait_irq(40);
    `CHK(z, 1, "wrap")
    `CHK((count_value inside {16'h0002, 16'h0003}), 1'b1, "count kept")
    `CHK(timer_out, 1'b1, "compare toggle")
    `CHK(n inside {[9:14]}, 1'b1, "compare time")
    $display("test compare done");
    setup(TPC_CAPTURE, 1'b1, 7'h00, 16'h0001, 16'h0000, 16'h0030);
    wait_irq(100);
    `CHK(pwm_value, 16'h0000, "reload interrupt")
    @(negedge sys_clk);
    c0 = count_value;
    want_level = 1'b1;
    wait_irq(20);
    `CHK(pwm_value > c0 && pwm_value - c0 <= 16'h000c, 1'b1, "captured")
    `CHK(count_value > pwm_value, 1'b1, "counting on")
    $display("test capture done");
    want_level = 1'b0;
    repeat (8) @(negedge sys_clk);
    setup(TPC_GATED, 1'b1, 7'h00, 16'h0001, 16'h0000, 16'h0010);
    repeat (8) @(negedge sys_clk);
    c0 = count_value;
    repeat (8) @(negedge sys_clk);
    `CHK(count_value, c0, "idle hold")
    want_level = 1'b1;
    wait_irq(60);
    `CHK(count_value, 16'h0001, "gated reload")
    `CHK(timer_out, 1'b0, "gated toggle")
    @(negedge sys_clk);
    want_level = 1'b0;
    wait_irq(20);
    `CHK(timer_in_level, 1'b0, "deassert")
    `CHK(timer_in_level != pol, 1'b1, "deassert source")
    repeat (4) @(negedge sys_clk);
    c0 = count_value;
    repeat (8) @(negedge sys_clk);
    `CHK(count_value, c0, "gate closed")
    $display("test gated done");
    @(negedge sys_clk);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    `CHK(({timer_out, timer_irq, timer_in_level, count_value, pwm_value}), 35'h0, "reset again")
    sys_rst = 1'b0;
    ofe = 1'b0;
    setup(TPC_COMPARE, 1'b0, 7'h00, 16'h0001, 16'h0000, 16'h0004);
    wait_irq(20);
    `CHK(timer_out, 1'b0, "output function off")
    `CHK(count_value, 16'h0005, "compare count after match")
    $display("test reset and output off done");
    stop_test();
  end
  // The tests need under a thousand cycles; twenty thousand means a hang.
  initial
  begin
    #80000;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // tpc_timer_tb
